// ===== src/mmap_defs.svh
// constants of the internal data memory map
// What this block does
// R1: program and data spaces separate; program up to 64K, low 4K/8K on-chip
// R2: external data up to 64K, reached only by external data move
// R3: 256 bytes on-chip RAM; lower 128 direct and indirect addressable
// R4: 80H-0FFH direct goes to registers, indirect to upper RAM, no alias
// R5: stack push and pop are indirect, so high stack uses upper RAM
// R6: four banks of eight registers map onto RAM 00H-1FH
// R7: bank 0 is active after reset
// R8: stack pointer resets to 07H and increments before each push
// R9: bits of bytes 20H-2FH addressable by bit addresses 0-7FH
// R10: bit n is bit n mod 8 of byte 20H plus n div 8
// R11: bytes 20H-2FH also readable and writable as whole bytes
// R12: bytes 30H-7FH are plain storage
// R13: each special register decoded at its fixed direct address
// R14: bit access only for special registers at multiples of eight
// R15: interrupt return clears in-progress flag of current level
// R16: subroutine return leaves in-progress flags unchanged
// R17: two bank select bits pick bank base 00H, 08H, 10H or 18H
// R18: reset loads defined contents, ports all ones
// R19: unassigned special addresses ignore writes, read undefined
`ifndef MMAP_DEFS_SVH
`define MMAP_DEFS_SVH
`define MM_PORT0 8'h80
`define MM_STACK_POINTER 8'h81
`define MM_DATA_PTR_LO 8'h82
`define MM_DATA_PTR_HI 8'h83
`define MM_POWER_CTRL 8'h87
`define MM_TIMER_CTRL 8'h88
`define MM_TIMER_MODE 8'h89
`define MM_TIMER0_LO 8'h8A
`define MM_TIMER1_LO 8'h8B
`define MM_TIMER0_HI 8'h8C
`define MM_TIMER1_HI 8'h8D
`define MM_PORT1 8'h90
`define MM_SERIAL_CTRL 8'h98
`define MM_SERIAL_BUF 8'h99
`define MM_PORT2 8'hA0
`define MM_INT_ENABLE 8'hA8
`define MM_PORT3 8'hB0
`define MM_INT_PRIORITY 8'hB8
`define MM_TIMER2_CTRL 8'hC8
`define MM_TIMER2_CAP_LO 8'hCA
`define MM_TIMER2_CAP_HI 8'hCB
`define MM_TIMER2_LO 8'hCC
`define MM_TIMER2_HI 8'hCD
`define MM_STATUS_WORD 8'hD0
`define MM_ACCUM 8'hE0
`define MM_AUX_OPERAND 8'hF0
`define MM_RST_ZERO 8'h00
`define MM_RST_PORT 8'hFF
`define MM_RST_STACK 8'h07
`define MM_UNDEF_RD 8'hFF
`define MM_BIT_BASE 8'h20
`define MM_BANK_LSB 3
`define MM_RAM_DEPTH 256
`define MM_PROG_ONCHIP 16'h2000
`endif

// ===== src/mmap_pkg.sv
// types of the internal data memory map
package mm_pkg;
    typedef enum logic [1:0] {
        MM_IDLE = 2'b00,
        MM_RD = 2'b01,
        MM_WR = 2'b10
    } mm_op_t;
    typedef enum logic [1:0] {
        MM_AS_DIRECT = 2'b00,
        MM_AS_INDIRECT = 2'b01,
        MM_AS_BIT = 2'b10,
        MM_AS_STACK = 2'b11
    } mm_space_t;
    typedef struct packed {
        mm_op_t op;
        mm_space_t space;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wbit;
    } mm_req_t;
    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
        logic rbit;
    } mm_rsp_t;
    typedef struct packed {
        logic ext_data;
        logic [15:0] addr;
    } mm_far_t;
endpackage

// ===== src/mmap_ram.sv
// on-chip data ram, 256 bytes of flip-flops
`timescale 1ns/100ps
`include "mmap_defs.svh"
module mm_ram
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [7:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem_ff [`MM_RAM_DEPTH];
    logic [7:0] nxt_mem [`MM_RAM_DEPTH];
    genvar g;
    generate
        for (g = 0; g < `MM_RAM_DEPTH; g++)
        begin : g_byte
            always_comb
            begin
                nxt_mem[g] = mem_ff[g];
                if (we && waddr == 8'(g))
                    nxt_mem[g] = wdata;
            end
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    mem_ff[g] <= `MM_RST_ZERO;
                else
                    mem_ff[g] <= nxt_mem[g];
            end
        end
    endgenerate
    assign rdata = mem_ff[raddr];
endmodule // mm_ram

// ===== src/mmap_top.sv
// data memory map decoder with special registers and stack
`timescale 1ns/100ps
`include "mmap_defs.svh"
module mm_top
(
    input wire logic mclk,
    input wire logic reset_n,
    input mm_pkg::mm_req_t req,
    input wire logic push,
    input wire logic pop,
    input wire logic [7:0] push_data,
    input wire logic int_enter,
    input wire logic int_level_high,
    input wire logic interrupt_return,
    input wire logic subroutine_return,
    input wire logic external_data_move,
    input wire logic [15:0] ext_addr,
    input wire logic [15:0] prog_addr,
    output mm_pkg::mm_rsp_t rsp,
    output logic [7:0] stack_pointer,
    output logic [7:0] accumulator,
    output logic [7:0] program_status_word,
    output logic [7:0] port0_latch,
    output logic [1:0] active_bank,
    output logic [1:0] in_progress,
    output mm_pkg::mm_far_t ext_bus,
    output logic prog_onchip
);
    import mm_pkg::*;
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst_n;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    assign rst_n = rst_sync_ff;

    localparam int NUM_REGS = 26;
    logic [7:0] reg_ff [NUM_REGS];
    logic [7:0] nxt_reg [NUM_REGS];
    // fixed direct address of each register slot
    localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
        `MM_PORT0,
        `MM_STACK_POINTER,
        `MM_DATA_PTR_LO,
        `MM_DATA_PTR_HI,
        `MM_POWER_CTRL,
        `MM_TIMER_CTRL,
        `MM_TIMER_MODE,
        `MM_TIMER0_LO,
        `MM_TIMER1_LO,
        `MM_TIMER0_HI,
        `MM_TIMER1_HI,
        `MM_PORT1,
        `MM_SERIAL_CTRL,
        `MM_SERIAL_BUF,
        `MM_PORT2,
        `MM_INT_ENABLE,
        `MM_PORT3,
        `MM_INT_PRIORITY,
        `MM_TIMER2_CTRL,
        `MM_TIMER2_CAP_LO,
        `MM_TIMER2_CAP_HI,
        `MM_TIMER2_LO,
        `MM_TIMER2_HI,
        `MM_STATUS_WORD,
        `MM_ACCUM,
        `MM_AUX_OPERAND
    };
    // value each slot takes while reset is held
    localparam logic [7:0] REG_RST [NUM_REGS] = '{
        `MM_RST_PORT,
        `MM_RST_STACK,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_PORT,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_PORT,
        `MM_RST_ZERO,
        `MM_RST_PORT,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO,
        `MM_RST_ZERO
    };
    localparam int STK_IDX = 1;
    localparam int STATUS_IDX = 23;
    localparam int ACCUM_IDX = 24;
    localparam int PORT0_IDX = 0;

    logic [1:0] flag_ff;
    logic [1:0] nxt_flag;
    mm_rsp_t rsp_ff;
    mm_rsp_t nxt_rsp;
    mm_far_t far_ff;
    mm_far_t nxt_far;
    logic pon_ff;
    logic nxt_pon;

    logic is_direct;
    logic is_bit;
    logic is_rd;
    logic is_wr;
    logic reg_space;
    logic [7:0] byte_addr;
    logic [2:0] bit_pos;
    logic [7:0] sp_inc;
    logic ram_we;
    logic [7:0] ram_waddr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_raddr;
    logic [7:0] ram_rdata;
    logic [7:0] reg_rdata;
    logic reg_hit;
    logic [4:0] reg_sel;
    logic bit_ok;

    assign is_rd = req.op == MM_RD;
    assign is_wr = req.op == MM_WR;
    assign is_bit = req.space == MM_AS_BIT;
    assign is_direct = req.space == MM_AS_DIRECT || is_bit;
    assign sp_inc = reg_ff[STK_IDX] + 8'h01;

    always_comb
    begin
        bit_pos = req.addr[2:0];
        if (is_bit && !req.addr[7])
            byte_addr = `MM_BIT_BASE + {4'h0, req.addr[6:3]}; // R9 R10
        else if (is_bit)
            byte_addr = {req.addr[7:3], 3'b000}; // R14
        else
            byte_addr = req.addr;
    end

    assign reg_space = is_direct && byte_addr[7]; // R4

    always_comb
    begin
        reg_hit = 1'b0;
        reg_sel = 5'h00;
        for (int i = 0; i < NUM_REGS; i++)
        begin
            if (REG_ADDR[i] == byte_addr)
            begin
                reg_hit = 1'b1; // R13
                reg_sel = 5'(i);
            end
        end
    end

    assign bit_ok = !is_bit || !req.addr[7] || reg_hit; // R14
    assign reg_rdata = reg_hit ? reg_ff[reg_sel] : `MM_UNDEF_RD; // R19

    always_comb
    begin
        if (push || pop)
            ram_raddr = reg_ff[STK_IDX]; // R5
        else
            ram_raddr = byte_addr; // R3 R11 R12
    end

    logic [7:0] cur_byte;
    assign cur_byte = reg_space ? reg_rdata : ram_rdata;

    always_comb
    begin
        ram_we = 1'b0;
        ram_waddr = byte_addr;
        ram_wdata = req.wdata;
        if (push)
        begin
            ram_we = 1'b1; // R5 R8
            ram_waddr = sp_inc;
            ram_wdata = push_data;
        end
        // a pop owns the ram read port, so a write then would merge garbage
        else if (is_wr && !pop && !reg_space && bit_ok)
        begin
            ram_we = 1'b1; // R4 R6 R12
            if (is_bit)
            begin
                ram_wdata = ram_rdata;
                ram_wdata[bit_pos] = req.wbit; // R10
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++)
        begin : g_reg
            always_comb
            begin
                nxt_reg[g] = reg_ff[g];
                if (g == STK_IDX && push)
                    nxt_reg[g] = sp_inc; // R8
                else if (g == STK_IDX && pop)
                    nxt_reg[g] = reg_ff[g] - 8'h01; // R5
                else if (!push && !pop && is_wr && reg_space && reg_hit &&
                    reg_sel == 5'(g))
                begin
                    if (is_bit)
                    begin
                        if (bit_ok)
                            nxt_reg[g][bit_pos] = req.wbit; // R14
                    end
                    else
                        nxt_reg[g] = req.wdata; // R13
                end
            end
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                    reg_ff[g] <= REG_RST[g]; // R7 R8 R18
                else
                    reg_ff[g] <= nxt_reg[g];
            end
        end
    endgenerate

    mm_ram u_ram
    (
        .clk(mclk),
        .rst_n(rst_n),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .raddr(ram_raddr),
        .rdata(ram_rdata)
    );

    always_comb
    begin
        nxt_flag = flag_ff;
        if (int_enter)
        begin
            if (int_level_high)
                nxt_flag[1] = 1'b1;
            else
                nxt_flag[0] = 1'b1;
        end
        else if (interrupt_return)
        begin
            if (flag_ff[1])
                nxt_flag[1] = 1'b0; // R15
            else
                nxt_flag[0] = 1'b0; // R15
        end
        else if (subroutine_return)
            nxt_flag = flag_ff; // R16
    end

    always_comb
    begin
        nxt_rsp.valid = (is_rd || pop) && bit_ok;
        nxt_rsp.rdata = `MM_RST_ZERO;
        nxt_rsp.rbit = 1'b0;
        if (pop)
            nxt_rsp.rdata = ram_rdata; // R5
        else if (is_rd)
        begin
            nxt_rsp.rdata = cur_byte; // R4
            nxt_rsp.rbit = cur_byte[bit_pos]; // R10
        end
    end

    // external data space is only reached through the move request
    always_comb
    begin
        nxt_far.ext_data = external_data_move; // R2
        nxt_far.addr = external_data_move ? ext_addr : 16'h0000; // R2
    end

    always_comb
    begin
        nxt_pon = prog_addr < `MM_PROG_ONCHIP; // R1
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_ff <= 2'b00;
            rsp_ff <= '0;
            far_ff <= '0;
            pon_ff <= 1'b0;
        end
        else
        begin
            flag_ff <= nxt_flag;
            rsp_ff <= nxt_rsp;
            far_ff <= nxt_far;
            pon_ff <= nxt_pon;
        end
    end

    assign rsp = rsp_ff;
    assign stack_pointer = reg_ff[STK_IDX];
    assign accumulator = reg_ff[ACCUM_IDX];
    assign program_status_word = reg_ff[STATUS_IDX];
    assign port0_latch = reg_ff[PORT0_IDX];
    assign active_bank = reg_ff[STATUS_IDX][`MM_BANK_LSB +: 2]; // R17
    assign in_progress = flag_ff;
    assign ext_bus = far_ff;
    assign prog_onchip = pon_ff;
endmodule // mm_top

// ===== testbench/mmap_monitor.sv
// port assertions for the data memory map
`timescale 1ns/100ps
module mm_monitor
(
    input wire logic mclk,
    input wire logic reset_n,
    input mm_pkg::mm_req_t req,
    input wire logic push,
    input wire logic pop,
    input wire logic int_enter,
    input wire logic interrupt_return,
    input wire logic subroutine_return,
    input mm_pkg::mm_rsp_t rsp,
    input wire logic [7:0] stack_pointer,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] program_status_word,
    input wire logic [7:0] port0_latch,
    input wire logic [1:0] active_bank,
    input wire logic [1:0] in_progress
);
    import mm_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    chk_reset_state:
    assert property ($rose(reset_n) |-> stack_pointer == 8'h07
        && port0_latch == 8'hFF && active_bank == 2'h0
        && in_progress == 2'h0) else $error("state after reset wrong");
    chk_push_preinc:
    assert property (push |=> stack_pointer == $past(stack_pointer) + 8'h01)
        else $error("push did not pre-increment");
    chk_pop_answer:
    assert property (pop && !push |=> rsp.valid
        && stack_pointer == $past(stack_pointer) - 8'h01)
        else $error("pop wrong");
    chk_bank_select:
    assert property (active_bank == program_status_word[4:3])
        else $error("bank select mismatch");
    chk_read_answer:
    assert property (req.op == MM_RD && req.space != MM_AS_BIT && !push
        |=> rsp.valid) else $error("read not answered");
    chk_no_answer:
    assert property (req.op != MM_RD && !pop |=> !rsp.valid)
        else $error("answer without request");
    chk_acc_write:
    assert property (req.op == MM_WR && req.space == MM_AS_DIRECT
        && req.addr == 8'hE0 && !push && !pop
        |=> accumulator == $past(req.wdata)) else $error("acc write lost");
    chk_indirect_alias:
    assert property (req.op == MM_WR && req.space == MM_AS_INDIRECT
        |=> $stable(port0_latch)) else $error("indirect hit a register");
    chk_iret_clear:
    assert property (interrupt_return && !int_enter && in_progress == 2'h2
        |=> in_progress == 2'h0) else $error("flag not cleared");
    chk_ret_keep:
    assert property (subroutine_return && !int_enter && !interrupt_return
        |=> $stable(in_progress)) else $error("flags disturbed");
endmodule // mm_monitor

// ===== testbench/mmap_core.sv
// behavioural processor core driving the memory map
`timescale 1ns/100ps
module mm_core
(
    input wire logic mclk,
    output mm_pkg::mm_req_t req,
    output logic push,
    output logic pop,
    output logic [7:0] push_data,
    output logic int_enter,
    output logic int_level_high,
    output logic interrupt_return,
    output logic subroutine_return,
    output logic external_data_move,
    output logic [15:0] ext_addr,
    output logic [15:0] prog_addr
);
    import mm_pkg::*;
    initial
    begin
        req = '0;
        {push, pop, push_data} = 10'h000;
        {int_enter, int_level_high, interrupt_return} = 3'h0;
        {subroutine_return, external_data_move} = 2'h0;
        {ext_addr, prog_addr} = 32'h0;
    end
    task automatic xfer(input mm_op_t o, input mm_space_t s,
        input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #2 req = '{o, s, a, d, d[0]};
        @(posedge mclk);
        #2 req.op = MM_IDLE;
    endtask
    task automatic stk(input logic u, input logic [7:0] d);
        @(posedge mclk);
        #2 {push, pop, push_data} = {u, !u, d};
        @(posedge mclk);
        #2 {push, pop} = 2'h0;
    endtask
    task automatic ctl(input logic [3:0] v);
        @(posedge mclk);
        #2 {int_enter, int_level_high, interrupt_return,
            subroutine_return} = v;
        @(posedge mclk);
        #2 {int_enter, int_level_high, interrupt_return,
            subroutine_return} = 4'h0;
    endtask
    task automatic far(input logic m, input logic [15:0] e, p);
        @(posedge mclk);
        #2 {external_data_move, ext_addr, prog_addr} = {m, e, p};
        @(posedge mclk);
        #2 external_data_move = 1'b0;
    endtask
endmodule // mm_core

// ===== testbench/internal_data_memory_map_tb.sv
// self-checking bench for the data memory map
`timescale 1ns/100ps
module internal_data_memory_map_tb;
    import mm_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    mm_req_t req;
    mm_rsp_t rsp;
    mm_far_t ext_bus;
    logic push, pop, int_enter, int_level_high, interrupt_return;
    logic subroutine_return, external_data_move, prog_onchip;
    logic [7:0] push_data, stack_pointer, accumulator;
    logic [7:0] program_status_word, port0_latch;
    logic [15:0] ext_addr, prog_addr;
    logic [1:0] active_bank, in_progress;
    int miscompares = 0;
    int total_checks = 0;
    always #12.5 mclk = ~mclk;
    mm_core core(.mclk, .req, .push, .pop, .push_data, .int_enter,
        .int_level_high, .interrupt_return, .subroutine_return,
        .external_data_move, .ext_addr, .prog_addr);
    mm_top dut(.mclk, .reset_n, .req, .push, .pop, .push_data, .int_enter,
        .int_level_high, .interrupt_return, .subroutine_return,
        .external_data_move, .ext_addr, .prog_addr, .rsp, .stack_pointer,
        .accumulator, .program_status_word, .port0_latch, .active_bank,
        .in_progress, .ext_bus, .prog_onchip);
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input mm_space_t s, input logic [7:0] a, e);
        core.xfer(MM_RD, s, a, 8'h00);
        cmp({rsp.valid, rsp.rdata}, {1'b1, e});
    endtask
    task automatic wr(input mm_space_t s, input logic [7:0] a, d);
        core.xfer(MM_WR, s, a, d);
    endtask
    task report_and_stop;
        if (miscompares == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge mclk);
        #2 reset_n = 1'b1;
        cmp({stack_pointer, port0_latch}, 16'h07FF);
        cmp({accumulator, program_status_word}, 16'h0);
        cmp({active_bank, in_progress}, 16'h0);
        repeat (2) @(posedge mclk);
        wr(MM_AS_DIRECT, 8'h80, 8'hAA);
        wr(MM_AS_INDIRECT, 8'h80, 8'hBB);
        rd(MM_AS_DIRECT, 8'h80, 8'hAA);
        rd(MM_AS_INDIRECT, 8'h80, 8'hBB);
        core.stk(1'b1, 8'h5A);
        cmp(stack_pointer, 16'h08);
        rd(MM_AS_INDIRECT, 8'h08, 8'h5A);
        rd(MM_AS_DIRECT, 8'h81, 8'h08);
        wr(MM_AS_DIRECT, 8'h81, 8'h9F);
        core.stk(1'b1, 8'h3C);
        rd(MM_AS_INDIRECT, 8'hA0, 8'h3C);
        rd(MM_AS_DIRECT, 8'hA0, 8'hFF);
        core.stk(1'b0, 8'h00);
        cmp({rsp.rdata, stack_pointer}, 16'h3C9F);
        wr(MM_AS_DIRECT, 8'h21, 8'h00);
        wr(MM_AS_BIT, 8'h0B, 8'h01);
        rd(MM_AS_DIRECT, 8'h21, 8'h08);
        wr(MM_AS_INDIRECT, 8'h2F, 8'h80);
        core.xfer(MM_RD, MM_AS_BIT, 8'h7F, 8'h00);
        cmp(rsp.rbit, 16'h1);
        wr(MM_AS_DIRECT, 8'h30, 8'h77);
        rd(MM_AS_INDIRECT, 8'h30, 8'h77);
        wr(MM_AS_DIRECT, 8'hE0, 8'hC3);
        wr(MM_AS_BIT, 8'hE2, 8'h01);
        cmp(accumulator, 16'hC7);
        for (int i = 0; i < 4; i++)
        begin
            wr(MM_AS_DIRECT, 8'hD0, 8'(i << 3));
            cmp(active_bank, 16'(i));
        end
        wr(MM_AS_DIRECT, 8'hF8, 8'h12);
        rd(MM_AS_DIRECT, 8'hF8, 8'hFF);
        core.ctl(4'hC);
        cmp(in_progress, 16'h2);
        core.ctl(4'h1);
        cmp(in_progress, 16'h2);
        core.ctl(4'h2);
        cmp(in_progress, 16'h0);
        core.ctl(4'h8);
        core.ctl(4'h2);
        cmp(in_progress, 16'h0);
        core.far(1'b1, 16'hABCD, 16'h1FFF);
        cmp(ext_bus.addr, 16'hABCD);
        cmp({ext_bus.ext_data, prog_onchip}, 16'h3);
        core.far(1'b0, 16'h1234, 16'h2000);
        cmp({ext_bus.ext_data, prog_onchip}, 16'h0);
        report_and_stop();
    end
    initial
    begin
        #100000;
        miscompares++;
        report_and_stop();
    end
endmodule // internal_data_memory_map_tb
bind mm_top mm_monitor mon(.mclk, .reset_n, .req, .push, .pop, .int_enter,
    .interrupt_return, .subroutine_return, .rsp, .stack_pointer,
    .accumulator, .program_status_word, .port0_latch, .active_bank,
    .in_progress);
